/* File: src/pulse_tick.sv */
// Frequency-to-square-wave generator using an exact Hz accumulator.
// Assumes freq is in Hz and the core clock runs at CLK_HZ.
`timescale 1ns/1ps
module pulse_tick #(
  parameter int CLK_HZ = 50_000_000
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic enable, // Generate while high
  input wire logic [15:0] freq, // Output frequency in Hz
  output logic level, // Square wave output
  output logic fall // One-cycle pulse at end of each output pulse
);
  // ==========================================================================
  if (CLK_HZ < 1 || CLK_HZ >= 2**27) begin : g_bad_clk
    $error("pulse_tick: CLK_HZ out of range");
  end

  logic [26:0] acc;
  logic [27:0] sum;
  // Two toggles per output period
  assign sum = {1'b0, acc} + {11'h000, freq, 1'b0};

  // Accumulate and toggle when a half period has passed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      level <= 1'b0;
      fall <= 1'b0;
    end else if (!enable) begin
      acc <= '0;
      level <= 1'b0;
      fall <= 1'b0;
    end else if (sum >= 28'(CLK_HZ)) begin
      acc <= 27'(sum - 28'(CLK_HZ));
      level <= ~level;
      fall <= level;
    end else begin
      acc <= sum[26:0];
      fall <= 1'b0;
    end
  end
endmodule : pulse_tick

/* File: src/pulse_train_pkg.sv */
// Constants, register map, field layouts and states of the two-channel pulse train unit.
// Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus.
package pulse_train_pkg;
  // ==========================================================================
  // Clock and sizing
  localparam int CLK_HZ = 50_000_000;
  localparam int CH_COUNT = 2;
  localparam int PIN_COUNT = 2;
  localparam logic [15:0] PIN_FIRST = 16'h0002;
  localparam logic [15:0] PIN_SECOND = 16'h0003;
  localparam logic [15:0] FREQ_MAX_A = 16'h4E20;
  localparam logic [15:0] FREQ_MAX_B = 16'h9C40;

  // ==========================================================================
  // Register map: channel base is bit 6, global block is bit 7
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PIN_SELECT = 8'h08;
  localparam logic [7:0] REG_FAULT_CODE = 8'h0C;
  localparam logic [7:0] REG_RUN_FREQ = 8'h10;
  localparam logic [7:0] REG_ACT_FREQ = 8'h14;
  localparam logic [7:0] REG_JOG_FREQ = 8'h18;
  localparam logic [7:0] REG_TARGET = 8'h1C;
  localparam logic [7:0] REG_EMITTED = 8'h20;
  localparam logic [7:0] REG_RAMP = 8'h24;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h80;
  localparam logic [7:0] REG_IRQ_MASK = 8'h84;
  localparam int ADR_GLOBAL_BIT = 7;
  localparam int ADR_CHAN_BIT = 6;
  localparam int RAMP_DECEL_LSB = 16;
  localparam int IRQ_DONE_POS = 0;
  localparam int IRQ_FAULT_POS = 1;

  // ==========================================================================
  // Reset values and fault codes
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_FREQ = 16'h0001;
  localparam logic [15:0] FAULT_RAMP = 16'h0002;
  localparam logic [15:0] FAULT_TARGET = 16'h0003;
  localparam logic [15:0] FAULT_HALT = 16'h0004;
  localparam logic [15:0] FAULT_FORCED = 16'h0005;

  // ==========================================================================
  // Control word layout (bit 0 is rungEnable)
  typedef struct packed {
    logic hardHalt;
    logic jogSteady;
    logic jogSingle;
    logic splitRampCounts;
    logic rampShape;
    logic rungEnable;
  } ch_ctrl_s;

  // Status word layout (bit 0 is completionFlag)
  typedef struct packed {
    logic enableStatus;
    logic jogSteadyFlag;
    logic jogSingleFlag;
    logic normalFlag;
    logic faultFlag;
    logic idleFlag;
    logic rampUpFlag;
    logic runPhaseFlag;
    logic decelPhaseFlag;
    logic completionFlag;
  } ch_stat_s;

  localparam int CTRL_W = $bits(ch_ctrl_s);
  localparam int STAT_W = $bits(ch_stat_s);

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_ACCEL = 8'b0000_0010,
    ST_RUN = 8'b0000_0100,
    ST_DECEL = 8'b0000_1000,
    ST_DONE = 8'b0001_0000,
    ST_JOG_SINGLE = 8'b0010_0000,
    ST_JOG_STEADY = 8'b0100_0000,
    ST_FAULT = 8'b1000_0000
  } gen_state_e;

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes
endpackage : pulse_train_pkg

/* File: src/pulse_train_unit.sv */
// Two-channel pulse train unit: Wishbone register file, profile sequencers,
// pin routing with force override, and a masked interrupt.
// Assumes a classic Wishbone master, pin-level force inputs from outside the
// clock domain, and that software writes the control word once per scan.
`timescale 1ns/1ps
// Contract
// - Each channel drives output 2 or 3, fixed by a parameter, read-only.
// - Forcing the owned output while running stops pulses and raises a fault.
// - Completion flag sets on successful finish; software only reads it.
// - Completion clears on a scan with the rung false; set wins over clear.
// - Decel flag is high exactly during the deceleration phase.
// - Run flag is high exactly during the constant-rate run phase.
// - Frequency words accept 0..20000 on series A, 0..40000 on series B.
// - Frequency words are 16 bits, signed on series A, unsigned on B.
// - Total pulse target is 32-bit signed, 0 to 2147483647, writable.
// - Read-only 32-bit count of emitted pulses.
// - Control bit lets accel and decel pulse counts differ.
// - Jog single status is read-only, apart from its request bit.
// - Second channel is an identical copy with its own variables.
// - Hard halt stops pulses low at once, aborts, and raises a fault.
// - Idle flag means not running and no fault; starts only from idle.
// - Normal flag covers accel, run, decel and done with no fault.
module pulse_train_unit
  import pulse_train_pkg::*;
#(
  parameter int HW_SERIES = 1,
  parameter logic [15:0] OUT_SEL0 = PIN_FIRST,
  parameter logic [15:0] OUT_SEL1 = PIN_SECOND
) (
  input wire logic core_clk, // Core clock, 50 MHz
  input wire logic rst, // Async reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte enables
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic [PIN_COUNT-1:0] forceEn, // Pin force request per output
  input wire logic [PIN_COUNT-1:0] forceVal, // Pin force level per output
  output logic [PIN_COUNT-1:0] outPin, // Embedded outputs 2 and 3
  output logic irq // Level interrupt
);
  // ==========================================================================
  // Elaboration checks
  if (HW_SERIES != 0 && HW_SERIES != 1) begin : g_bad_series
    $error("pulse_train_unit: HW_SERIES must be 0 or 1");
  end
  if ((OUT_SEL0 != PIN_FIRST && OUT_SEL0 != PIN_SECOND) ||
      (OUT_SEL1 != PIN_FIRST && OUT_SEL1 != PIN_SECOND)) begin : g_bad_pin
    $error("pulse_train_unit: output select must be 2 or 3");
  end

  localparam logic [15:0] OUT_SEL [CH_COUNT] = '{OUT_SEL0, OUT_SEL1};

  // Frequency range check per series
  function automatic logic freqBad(input logic [15:0] f);
    if (HW_SERIES == 0) begin
      return f[15] || (f > FREQ_MAX_A);
    end
    return f > FREQ_MAX_B;
  endfunction : freqBad

  // ==========================================================================
  // Bus decode
  logic wbReq;
  logic wbWr;
  logic [7:0] regOff;
  logic [31:0] rdData;
  logic [31:0] chRd [CH_COUNT];
  logic [2*CH_COUNT-1:0] irqStatus;
  logic [2*CH_COUNT-1:0] irqMask;
  logic [2*CH_COUNT-1:0] irqEvents;
  logic [PIN_COUNT-1:0] forceEnSync;
  logic [PIN_COUNT-1:0] forceValSync;
  logic [PIN_COUNT-1:0] chDrive [CH_COUNT];
  logic [CH_COUNT-1:0] chHalt;

  assign wbReq = cyc_i & stb_i & ~ack_o;
  assign wbWr = wbReq & we_i;
  assign regOff = {2'b00, adr_i[5:2], 2'b00};

  // Pin force inputs come from outside the clock domain
  sync2 #(.WIDTH(2 * PIN_COUNT)) u_force_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async({forceVal, forceEn}),
    .synced({forceValSync, forceEnSync})
  );

  // ==========================================================================
  // Channels
  for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
    ch_ctrl_s ctrl;
    ch_stat_s stat;
    gen_state_e state;
    logic [15:0] runFreq;
    logic [15:0] jogFreq;
    logic [15:0] actFreq;
    logic [15:0] faultCode;
    logic [31:0] target;
    logic [31:0] rampCounts;
    logic [31:0] emitted;
    logic [31:0] accelN;
    logic [31:0] decelN;
    logic [15:0] rampFreq;
    logic chWr;
    logic ctrlWr;
    logic [31:0] wrWord;
    logic rungPrev;
    logic jogPrev;
    logic startEdge;
    logic jogEdge;
    logic startGo;
    logic moving;
    logic jogging;
    logic forced;
    logic completion;
    logic tickLevel;
    logic tickFall;
    logic pinIdx;

    assign pinIdx = (OUT_SEL[g] == PIN_SECOND);
    assign chWr = wbWr & ~adr_i[ADR_GLOBAL_BIT] & (adr_i[ADR_CHAN_BIT] == 1'(g));
    assign ctrlWr = chWr & (regOff == REG_CTRL);
    assign moving = (state == ST_ACCEL) | (state == ST_RUN) | (state == ST_DECEL);
    assign jogging = (state == ST_JOG_SINGLE) | (state == ST_JOG_STEADY);
    assign forced = forceEnSync[pinIdx];
    assign startEdge = ctrl.rungEnable & ~rungPrev;
    assign jogEdge = ctrl.jogSingle & ~jogPrev;
    assign accelN = {16'h0000, rampCounts[15:0]};
    assign decelN = ctrl.splitRampCounts ? {16'h0000, rampCounts[31:RAMP_DECEL_LSB]}
                                          : accelN;
    // Start only from idle with jog and halt released and pin not forced
    assign startGo = (state == ST_IDLE) & startEdge & ~ctrl.jogSingle & ~ctrl.jogSteady &
                     ~ctrl.hardHalt & ~forced;

    // Select the merged write word for the addressed register
    always_comb begin
      case (regOff)
        REG_CTRL: wrWord = mergeBytes({{(32-CTRL_W){1'b0}}, ctrl}, dat_i, sel_i);
        REG_RUN_FREQ: wrWord = mergeBytes({16'h0000, runFreq}, dat_i, sel_i);
        REG_JOG_FREQ: wrWord = mergeBytes({16'h0000, jogFreq}, dat_i, sel_i);
        REG_TARGET: wrWord = mergeBytes(target, dat_i, sel_i);
        REG_RAMP: wrWord = mergeBytes(rampCounts, dat_i, sel_i);
        default: wrWord = RESET_WORD;
      endcase
    end

    // Software-written control and setting words
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        ctrl <= '0;
        runFreq <= RESET_WORD[15:0];
        jogFreq <= RESET_WORD[15:0];
        target <= RESET_WORD;
        rampCounts <= RESET_WORD;
      end else if (chWr) begin
        case (regOff)
          REG_CTRL: ctrl <= ch_ctrl_s'(wrWord[CTRL_W-1:0]);
          REG_RUN_FREQ: runFreq <= wrWord[15:0];
          REG_JOG_FREQ: jogFreq <= wrWord[15:0];
          REG_TARGET: target <= wrWord;
          REG_RAMP: rampCounts <= wrWord;
          default: ;
        endcase
      end
    end

    // Edge memories for rung and jog request
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        rungPrev <= 1'b0;
        jogPrev <= 1'b0;
      end else begin
        rungPrev <= ctrl.rungEnable;
        jogPrev <= ctrl.jogSingle;
      end
    end

    // Profile sequencer
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        state <= ST_IDLE;
        faultCode <= FAULT_NONE;
      end else if (ctrl.hardHalt && state != ST_FAULT) begin
        state <= ST_FAULT;
        faultCode <= FAULT_HALT;
      end else if (forced && (moving || jogging)) begin
        state <= ST_FAULT;
        faultCode <= FAULT_FORCED;
      end else begin
        case (state)
          ST_IDLE: begin
            if (startGo) begin
              if (freqBad(runFreq)) begin
                state <= ST_FAULT;
                faultCode <= FAULT_FREQ;
              end else if (target[31]) begin
                state <= ST_FAULT;
                faultCode <= FAULT_TARGET;
              end else if (accelN + decelN > target) begin
                state <= ST_FAULT;
                faultCode <= FAULT_RAMP;
              end else if (target == 32'h0000_0000) begin
                state <= ST_DONE;
              end else if (accelN != 32'h0000_0000) begin
                state <= ST_ACCEL;
              end else if (decelN >= target) begin
                state <= ST_DECEL;
              end else begin
                state <= ST_RUN;
              end
            end else if ((jogEdge || ctrl.jogSteady) && !forced) begin
              if (freqBad(jogFreq)) begin
                state <= ST_FAULT;
                faultCode <= FAULT_FREQ;
              end else begin
                state <= jogEdge ? ST_JOG_SINGLE : ST_JOG_STEADY;
              end
            end
          end
          ST_ACCEL, ST_RUN, ST_DECEL: begin
            // Phase follows the count of completed pulses
            if (tickFall) begin
              if (emitted + 32'h1 >= target) begin
                state <= ST_DONE;
              end else if (emitted + 32'h1 < accelN) begin
                state <= ST_ACCEL;
              end else if (emitted + 32'h1 >= target - decelN) begin
                state <= ST_DECEL;
              end else begin
                state <= ST_RUN;
              end
            end
          end
          ST_DONE: begin
            if (!ctrl.rungEnable) begin
              state <= ST_IDLE;
            end
          end
          ST_JOG_SINGLE: begin
            if (tickFall) begin
              state <= ST_IDLE;
            end
          end
          ST_JOG_STEADY: begin
            if (!ctrl.jogSteady) begin
              state <= ST_IDLE;
            end
          end
          ST_FAULT: begin
            // Leave the fault once halt, rung and jog requests are all released
            if (!ctrl.hardHalt && !ctrl.rungEnable && !ctrl.jogSingle && !ctrl.jogSteady) begin
              state <= ST_IDLE;
              faultCode <= FAULT_NONE;
            end
          end
          default: begin
            state <= ST_FAULT;
            faultCode <= FAULT_NONE;
          end
        endcase
      end
    end

    // Count of emitted pulses, cleared at each start
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        emitted <= RESET_WORD;
      end else if (startGo) begin
        emitted <= RESET_WORD;
      end else if (moving && tickFall) begin
        emitted <= emitted + 32'h1;
      end
    end

    // Completion flag: set on finish, cleared by a scan with the rung false
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        completion <= 1'b0;
      end else if (moving && tickFall && emitted + 32'h1 >= target) begin
        completion <= 1'b1;
      end else if (startGo && !freqBad(runFreq) && (target | accelN | decelN) == 32'h0) begin
        completion <= 1'b1;
      end else if (ctrlWr && !wrWord[0]) begin
        completion <= 1'b0;
      end
    end

    // Ramp rate: half of run rate for trapezoid, quarter for S-curve
    always_comb begin
      rampFreq = ctrl.rampShape ? {2'b00, runFreq[15:2]} : {1'b0, runFreq[15:1]};
      if (rampFreq == 16'h0000) begin
        rampFreq = 16'h0001;
      end
    end

    // Actual frequency word driven into the generator
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        actFreq <= RESET_WORD[15:0];
      end else if (jogging) begin
        actFreq <= jogFreq;
      end else if (state == ST_RUN) begin
        actFreq <= runFreq;
      end else if (state == ST_ACCEL || state == ST_DECEL) begin
        actFreq <= rampFreq;
      end else begin
        actFreq <= RESET_WORD[15:0];
      end
    end

    pulse_tick #(.CLK_HZ(CLK_HZ)) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .enable((moving | jogging) & ~ctrl.hardHalt),
      .freq(actFreq),
      .level(tickLevel),
      .fall(tickFall)
    );

    // Status word
    assign stat.completionFlag = completion;
    assign stat.decelPhaseFlag = (state == ST_DECEL);
    assign stat.runPhaseFlag = (state == ST_RUN);
    assign stat.rampUpFlag = (state == ST_ACCEL);
    assign stat.idleFlag = (state == ST_IDLE);
    assign stat.faultFlag = (state == ST_FAULT);
    assign stat.normalFlag = moving | (state == ST_DONE);
    assign stat.jogSingleFlag = (state == ST_JOG_SINGLE);
    assign stat.jogSteadyFlag = (state == ST_JOG_STEADY);
    assign stat.enableStatus = ctrl.rungEnable & (state != ST_DONE);

    // Pin drive and halt for the shared output stage
    assign chDrive[g] = {PIN_COUNT{tickLevel}} & (pinIdx ? 2'b10 : 2'b01);
    assign chHalt[g] = ctrl.hardHalt;
    assign irqEvents[2*g + IRQ_DONE_POS] = moving & tickFall & (emitted + 32'h1 >= target);
    assign irqEvents[2*g + IRQ_FAULT_POS] = (state != ST_FAULT) &
                                            (ctrl.hardHalt | (forced & (moving | jogging)));

    // Channel read mux
    always_comb begin
      case (regOff)
        REG_CTRL: chRd[g] = {{(32-CTRL_W){1'b0}}, ctrl};
        REG_STATUS: chRd[g] = {{(32-STAT_W){1'b0}}, stat};
        REG_PIN_SELECT: chRd[g] = {16'h0000, OUT_SEL[g]};
        REG_FAULT_CODE: chRd[g] = {16'h0000, faultCode};
        REG_RUN_FREQ: chRd[g] = {16'h0000, runFreq};
        REG_ACT_FREQ: chRd[g] = {16'h0000, actFreq};
        REG_JOG_FREQ: chRd[g] = {16'h0000, jogFreq};
        REG_TARGET: chRd[g] = target;
        REG_EMITTED: chRd[g] = emitted;
        REG_RAMP: chRd[g] = rampCounts;
        default: chRd[g] = RESET_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Output pins: forced level wins, halt drives low at once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outPin <= '0;
    end else begin
      for (int p = 0; p < PIN_COUNT; p++) begin
        if (forceEnSync[p]) begin
          outPin[p] <= forceValSync[p];
        end else begin
          outPin[p] <= (chDrive[0][p] & ~chHalt[0]) | (chDrive[1][p] & ~chHalt[1]);
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqStatus <= '0;
      irqMask <= '0;
    end else begin
      if (wbWr && {adr_i[7:2], 2'b00} == REG_IRQ_MASK && sel_i[0]) begin
        irqMask <= dat_i[2*CH_COUNT-1:0];
      end
      if (wbWr && {adr_i[7:2], 2'b00} == REG_IRQ_STATUS && sel_i[0]) begin
        irqStatus <= (irqStatus & ~dat_i[2*CH_COUNT-1:0]) | irqEvents;
      end else begin
        irqStatus <= irqStatus | irqEvents;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ==========================================================================
  // Read mux and acknowledge; unmapped addresses read zero and are acked
  always_comb begin
    if (!adr_i[ADR_GLOBAL_BIT]) begin
      rdData = chRd[adr_i[ADR_CHAN_BIT]];
    end else if ({adr_i[7:2], 2'b00} == REG_IRQ_STATUS) begin
      rdData = {{(32-2*CH_COUNT){1'b0}}, irqStatus};
    end else if ({adr_i[7:2], 2'b00} == REG_IRQ_MASK) begin
      rdData = {{(32-2*CH_COUNT){1'b0}}, irqMask};
    end else begin
      rdData = RESET_WORD;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= RESET_WORD;
    end else begin
      ack_o <= wbReq;
      dat_o <= wbReq ? rdData : RESET_WORD;
    end
  end
endmodule : pulse_train_unit

/* File: src/sync2.sv */
// Two-stage synchroniser for pin-level inputs.
// Assumes inputs are levels from outside the core clock domain.
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic [WIDTH-1:0] async, // Asynchronous levels
  output logic [WIDTH-1:0] synced // Synchronised levels
);
  // ==========================================================================
  // First stage feeds only the second stage
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule : sync2

/* File: tb/pulse_train_unit_chk.sv */
// Checker on the pulse train unit ports: bus answers and pin control.
// Assumes one core clock; bound at the foot of this file.
`timescale 1ns/1ps
module pulse_train_unit_chk import pulse_train_pkg::*; (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write
  input wire logic [7:0] adr_i, // Address
  input wire logic [31:0] dat_o, // Read data
  input wire logic ack_o, // Ack
  input wire logic [PIN_COUNT-1:0] forceEn, // Force on
  input wire logic [PIN_COUNT-1:0] forceVal, // Force level
  input wire logic [PIN_COUNT-1:0] outPin // Pins
);
  wire rq = cyc_i && stb_i && !ack_o;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Bus answers, read-only words and forced pin
  chk_ack_answer: assert property (rq |=> ack_o) else $error("no ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
  chk_ack_cause: assert property (ack_o |-> $past(rq)) else $error("stray ack");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not idle");
  chk_pin_sel: assert property (rq && !we_i && adr_i == 8'h08 |=> dat_o == 32'h2)
    else $error("pin select 0");
  chk_pin_sel1: assert property (rq && !we_i && adr_i == 8'h48 |=> dat_o == 32'h3)
    else $error("pin select 1");
  chk_unmapped_zero: assert property (rq && !we_i && adr_i == 8'h3C |=> dat_o == 32'h0)
    else $error("unmapped read");
  chk_force_pin: assert property ((forceEn[0] && forceVal[0]) [*6] |-> outPin[0])
    else $error("force ignored");
endmodule : pulse_train_unit_chk
bind pulse_train_unit pulse_train_unit_chk i_chk (.core_clk(core_clk), .rst(rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .forceEn(forceEn), .forceVal(forceVal), .outPin(outPin));

/* File: tb/pulse_train_unit_tb_top.sv */
// Bench for the pulse train unit; reads are checked from a queue.
// Assumes the design's one-cycle Wishbone answer.
`timescale 1ns/1ps
module pulse_train_unit_tb_top;
  logic core_clk = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, ack, irq;
  logic [1:0] fEn = 2'h0, fVal = 2'h0, pin;
  logic [7:0] ad = 8'h0;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic [63:0] q[$], e;
  int error_cnt = 0, tests_run = 0, pulses;
  pulse_train_unit i_dut (.core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(cyc),
    .we_i(we), .adr_i(ad), .sel_i(4'hF), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
    .forceEn(fEn), .forceVal(fVal), .outPin(pin), .irq(irq));
  step_input_model i_drv (.rst(rst), .step(pin[0]), .pulses(pulses));
  initial forever #10 core_clk = ~core_clk; // 50 MHz
  task automatic cmp(input logic [31:0] x, g);
    tests_run++;
    if (g !== x) error_cnt++;
    if (g !== x) $display("wrong value at %0t: %h vs %h", $time, x, g);
  endtask : cmp
  task automatic close_out;
    $display("%0d compares, %0d wrong", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // One Wishbone cycle; a read with a nonzero mask notes its expected value and mask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m = 32'hFFFFFFFF);
    int n = 0;
    @(posedge core_clk);
    {cyc, we, ad, wd} <= {1'h1, w, a, d};
    if (!w && m != 32'h0) q.push_back({d, m});
    do @(posedge core_clk); while (ack !== 1'h1 && ++n < 20);
    rd = rdat;
    cyc <= 1'h0;
    if (n >= 20) error_cnt++;
    if (n >= 20) close_out();
  endtask : bus
  // Take the oldest note off the queue at each read answer
  always @(posedge core_clk) if (ack === 1'h1 && !we && q.size() > 0) begin
    e = q.pop_front();
    cmp(e[63:32], rdat & e[31:0]);
  end
  initial begin // Main sequence
    void'($urandom(48744));
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    bus(1'h0, 8'h08, 32'h2);
    bus(1'h0, 8'h48, 32'h3);
    bus(1'h0, 8'h3C, 32'h0);
    bus(1'h1, 8'h10, 32'h4E20 + $urandom % 32'h4E20);
    bus(1'h1, 8'h1C, 32'h3);
    bus(1'h1, 8'h84, 32'h1);
    bus(1'h1, 8'h00, 32'h1);
    for (int i = 0; i < 9000 && !rd[0]; i++) bus(1'h0, 8'h04, 32'h0, 32'h0);
    if (!rd[0]) error_cnt++;
    if (!rd[0]) close_out();
    bus(1'h0, 8'h04, 32'h41, 32'h7F);
    bus(1'h0, 8'h20, 32'h3);
    cmp(32'h3, pulses);
    cmp(32'h1, {31'h0, irq});
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h80, 32'h1);
    bus(1'h0, 8'h04, 32'h10, 32'h7F);
    $display("test run done");
    bus(1'h1, 8'h00, 32'h1);
    repeat (4) @(posedge core_clk);
    {fEn, fVal} <= 4'h5;
    repeat (8) @(posedge core_clk);
    bus(1'h0, 8'h0C, 32'h5);
    cmp(32'h0, {31'h0, irq});
    $display("test force done");
    close_out();
  end
endmodule : pulse_train_unit_tb_top

/* File: tb/step_input_model.sv */
// Stepper drive input model: counts the step pulses seen on the pulse pin.
// Assumes the pin is a registered level from the unit.
`timescale 1ns/1ps
module step_input_model (
  input wire logic rst, // Async reset, active high
  input wire logic step, // Step input from the pulse pin
  output int pulses // Rising step edges seen
);
  // The drive moves one step on each rising edge of its input
  always_ff @(posedge step or posedge rst) begin
    if (rst) pulses <= 0;
    else pulses <= pulses + 1;
  end
endmodule : step_input_model
